// ---- logic/src_map.vh ----
// Purpose: Offsets, field positions, reset values and timing counts of the
//          serial ROM command engine.
// Assumes: 100 MHz engine clock, 32-bit AXI4-Lite register bus.
// Notes:   Definitions only; included by bare name.
`ifndef SRC_MAP_VH
`define SRC_MAP_VH

// ======================================================================
// Register byte offsets
`define SRC_CMD_OFS      8'h00
`define SRC_DATA_OFS     8'h04
`define SRC_STAL_OFS     8'h08
`define SRC_STAH_OFS     8'h0C
`define SRC_PCFG_OFS     8'h10

// ======================================================================
// Command register fields
`define SRC_CMD_BUSY     31
`define SRC_CMD_OPC_HI   30
`define SRC_CMD_OPC_LO   28
`define SRC_CMD_TO       9
`define SRC_CMD_LOADED   8
`define SRC_CMD_LOC_HI   6

// Host operation codes in the opcode field.
`define SRC_OP_READ      3'h0
`define SRC_OP_LOCK      3'h1
`define SRC_OP_UNLOCK    3'h2
`define SRC_OP_WRITE     3'h3
`define SRC_OP_FILL      3'h4
`define SRC_OP_ERASE     3'h5
`define SRC_OP_ERASEALL  3'h6
`define SRC_OP_RELOAD    3'h7

// ======================================================================
// Serial ROM opcodes and fixed address patterns of the special commands
`define SRC_ROP_READ     2'h2
`define SRC_ROP_WRITE    2'h1
`define SRC_ROP_ERASE    2'h3
`define SRC_ROP_SPECIAL  2'h0
`define SRC_RA_UNLOCK    7'h60
`define SRC_RA_LOCK      7'h00
`define SRC_RA_ERASEALL  7'h40
`define SRC_RA_FILL      7'h20
`define SRC_SIGNATURE    8'hA5
`define SRC_STA_LAST     3'h6
`define SRC_BITS_SHORT   5'h0A
`define SRC_BITS_LONG    5'h12
`define SRC_HDR_BITS     5'h0A

// ======================================================================
// Reset values, bus answers and timing
`define SRC_PCFG_RST     1'b1
`define SRC_RESP_OKAY    2'h0
`define SRC_RESP_SLVERR  2'h2
`define SRC_SCLK_HALF    6'h32       // 1 MHz serial clock from 100 MHz.
`define SRC_TIMEOUT_CYC  22'h2DC6C0  // 30 ms of 10 ns cycles.

`endif

// ---- logic/src_shifter.v ----
// Purpose: Bit engine for the serial ROM: divides the clock into the
//          serial clock and shifts one command frame out and in.
// Assumes: i_din_sync is already synchronised to i_clk.
// Notes:   Bits change while the serial clock is low; input is sampled
//          at the end of the high phase.
`timescale 1ns/100ps
`include "src_map.vh"

module src_shifter (
  // Clock and reset.
  input  wire        i_clk,
  input  wire        i_srst,
  // Frame request.
  input  wire        i_start,
  input  wire        i_read,
  input  wire [4:0]  i_nbits,
  input  wire [17:0] i_word,
  output reg         o_done,
  output wire [7:0]  o_rx_byte,
  // Pin side.
  output reg         o_sclk,
  output reg         o_dout,
  output reg         o_drive,
  input  wire        i_din_sync
);

  localparam [5:0] HALF_M1 = `SRC_SCLK_HALF - 6'h01;

  reg        busy_q;
  reg        read_q;
  reg        phase_q;
  reg [5:0]  half_q;
  reg [4:0]  bit_q;
  reg [4:0]  nbits_q;
  reg [17:0] sh_q;
  reg [7:0]  rx_q;
  wire       tick;
  wire [4:0] bit_next;

  // One-cycle enable at each serial clock half period.
  assign tick      = busy_q && (half_q == HALF_M1);
  assign bit_next  = bit_q + 5'h01;
  assign o_rx_byte = rx_q;

  // ======================================================================
  // Frame sequencer.
  // The frame is MSB first: start bit, opcode, address, then data.
  always @(posedge i_clk) begin
    o_done <= 1'b0;
    if (i_srst) begin
      busy_q  <= 1'b0;
      read_q  <= 1'b0;
      phase_q <= 1'b0;
      half_q  <= 6'h00;
      bit_q   <= 5'h00;
      nbits_q <= 5'h00;
      sh_q    <= 18'h00000;
      rx_q    <= 8'h00;
      o_sclk  <= 1'b0;
      o_dout  <= 1'b0;
      o_drive <= 1'b0;
    end else if (i_start && !busy_q) begin
      busy_q  <= 1'b1;
      read_q  <= i_read;
      phase_q <= 1'b0;
      half_q  <= 6'h00;
      bit_q   <= 5'h00;
      nbits_q <= i_nbits;
      sh_q    <= i_word;
      o_dout  <= i_word[17];
      o_drive <= 1'b1;
    end else if (busy_q) begin
      half_q <= tick ? 6'h00 : half_q + 6'h01;
      if (tick && !phase_q) begin
        o_sclk  <= 1'b1;  // ROM samples on this rising edge
        phase_q <= 1'b1;
      end else if (tick) begin
        o_sclk  <= 1'b0;
        phase_q <= 1'b0;
        rx_q    <= {rx_q[6:0], i_din_sync};
        bit_q   <= bit_next;
        if (bit_next == nbits_q) begin
          busy_q  <= 1'b0;  // exact clock count
          o_done  <= 1'b1;
          o_dout  <= 1'b0;
          o_drive <= 1'b0;
        end else begin
          sh_q    <= {sh_q[16:0], 1'b0};
          o_dout  <= sh_q[16];
          // The ROM owns the data pin during read data bits.
          o_drive <= !(read_q && (bit_next >= `SRC_HDR_BITS));
        end
      end
    end
  end

endmodule // src_shifter

// ---- logic/src_engine.v ----
// Purpose: Serial ROM command engine with AXI4-Lite registers, station
//          address auto-load and host-driven ROM operations.
// Assumes: 100 MHz i_clk, synchronous active-high reset, ROM of 128 bytes.
// Notes:   Host writes to the command register while busy only clear the timeout flag.
//
// Our own choices: the AXI4-Lite interface to the registers and the register offsets.
`timescale 1ns/100ps
`include "src_map.vh"

module src_engine #(
  parameter [21:0] TIMEOUT_CYCLES = `SRC_TIMEOUT_CYC
) (
  // Clock and reset.
  input  wire        i_clk,
  input  wire        i_srst,
  // AXI4-Lite write address and data.
  input  wire        i_awvalid,
  output wire        o_awready,
  input  wire [7:0]  i_awaddr,
  input  wire        i_wvalid,
  output wire        o_wready,
  input  wire [31:0] i_wdata,
  input  wire [3:0]  i_wstrb,
  // AXI4-Lite write response.
  output reg         o_bvalid,
  input  wire        i_bready,
  output reg  [1:0]  o_bresp,
  // AXI4-Lite read.
  input  wire        i_arvalid,
  output wire        o_arready,
  input  wire [7:0]  i_araddr,
  output reg         o_rvalid,
  input  wire        i_rready,
  output reg  [31:0] o_rdata,
  output reg  [1:0]  o_rresp,
  // Serial ROM pins.
  output reg         o_rom_select,
  output wire        o_rom_clock_pin_out,
  output wire        o_rom_clock_pin_oe,
  output wire        o_rom_data_pin_out,
  output wire        o_rom_data_pin_oe,
  input  wire        i_rom_data_pin_in,
  // Station address and pin release to the rest of the chip.
  output wire [47:0] o_station_addr,
  output wire        o_pins_released
);

  // ======================================================================
  // States and constants
  localparam [2:0] S_IDLE  = 3'h0;
  localparam [2:0] S_LOAD  = 3'h1;
  localparam [2:0] S_SHIFT = 3'h2;
  localparam [2:0] S_GAP   = 3'h3;
  localparam [2:0] S_POLL  = 3'h4;
  localparam [5:0] GAP_M1  = `SRC_SCLK_HALF - 6'h01;
  localparam [21:0] TO_M1  = TIMEOUT_CYCLES - 22'h000001;

  // ======================================================================
  // Declarations
  reg  [2:0]  state_q;
  reg         busy_q;
  reg  [2:0]  opc_q;
  reg  [6:0]  loc_q;
  reg         timeout_q;
  reg         loaded_q;
  reg  [7:0]  data_q;
  reg  [47:0] sta_q;
  reg         en_q;
  reg         load_q;
  reg  [2:0]  idx_q;
  reg         poll_q;
  reg         rd_op_q;
  reg  [21:0] to_cnt_q;
  reg  [5:0]  gap_q;
  reg         start_q;
  reg         sh_read_q;
  reg  [4:0]  sh_nbits_q;
  reg  [17:0] sh_word_q;
  reg         din_meta_q;
  reg         din_sync_q;
  reg         aw_hold_q;
  reg  [7:0]  awaddr_q;
  reg         w_hold_q;
  reg  [31:0] wdata_q;
  reg  [3:0]  wstrb_q;
  wire        sh_done;
  wire [7:0]  sh_rx;
  wire        sh_sclk;
  wire        sh_dout;
  wire        sh_drive;
  wire        wr_fire;
  wire        rd_fire;
  wire [31:0] cmd_view;
  wire [31:0] wr_merged;
  wire        to_hit;
  wire [2:0]  sta_slot;

  // ======================================================================
  // Functions
  // Builds one ROM frame, left aligned so short frames use the top bits.
  function [17:0] rom_word;
    input [1:0] op;
    input [6:0] addr;
    input [7:0] dat;
    begin
      rom_word = {1'b1, op, addr, dat};
    end
  endfunction

  // Merges a bus write into a register image under the byte strobes.
  function [31:0] merge;
    input [31:0] old;
    input [31:0] nw;
    input [3:0]  strb;
    integer k;
    begin
      merge = old;
      for (k = 0; k < 4; k = k + 1) begin
        if (strb[k]) begin
          merge[k*8 +: 8] = nw[k*8 +: 8];
        end
      end
    end
  endfunction

  // Register image as software sees it, for reads and merges.
  function [31:0] reg_view;
    input [7:0] addr;
    begin
      if (addr == `SRC_CMD_OFS) begin
        reg_view = cmd_view;
      end else if (addr == `SRC_DATA_OFS) begin
        reg_view = {24'h000000, data_q};
      end else if (addr == `SRC_STAL_OFS) begin
        reg_view = sta_q[31:0];
      end else if (addr == `SRC_STAH_OFS) begin
        reg_view = {16'h0000, sta_q[47:32]};
      end else if (addr == `SRC_PCFG_OFS) begin
        reg_view = {31'h00000000, en_q};
      end else begin
        reg_view = 32'h00000000;
      end
    end
  endfunction

  // True for any mapped word address.
  function mapped;
    input [7:0] addr;
    begin
      mapped = (addr == `SRC_CMD_OFS) || (addr == `SRC_DATA_OFS) ||
               (addr == `SRC_STAL_OFS) || (addr == `SRC_STAH_OFS) ||
               (addr == `SRC_PCFG_OFS);
    end
  endfunction

  // ======================================================================
  // Combinational views
  assign cmd_view = {busy_q, opc_q, 18'h00000, timeout_q, loaded_q,
                     1'b0, loc_q};
  assign wr_fire   = aw_hold_q && w_hold_q && !o_bvalid;
  assign rd_fire   = i_arvalid && !o_rvalid;
  assign o_awready = !aw_hold_q && !o_bvalid;
  assign o_wready  = !w_hold_q && !o_bvalid;
  assign o_arready = !o_rvalid;
  assign wr_merged = merge(reg_view(awaddr_q), wdata_q, wstrb_q);
  assign to_hit    = (to_cnt_q == TO_M1);
  assign sta_slot  = idx_q - 3'h1;
  assign o_station_addr      = sta_q;
  assign o_pins_released     = !en_q;
  // Disabled interface lets go of both pins for other uses.
  assign o_rom_clock_pin_out = sh_sclk;
  assign o_rom_clock_pin_oe  = en_q;
  assign o_rom_data_pin_out  = sh_dout;
  assign o_rom_data_pin_oe   = en_q && sh_drive;

  // ======================================================================
  // Data pin synchroniser; only the second stage feeds logic.
  always @(posedge i_clk) begin
    if (i_srst) begin
      din_meta_q <= 1'b0;
      din_sync_q <= 1'b0;
    end else begin
      din_meta_q <= i_rom_data_pin_in;
      din_sync_q <= din_meta_q;
    end
  end

  // ======================================================================
  // AXI4-Lite channel capture and answers.
  // Address and data are held separately so they may arrive in any order.
  always @(posedge i_clk) begin
    if (i_srst) begin
      aw_hold_q <= 1'b0;
      awaddr_q  <= 8'h00;
      w_hold_q  <= 1'b0;
      wdata_q   <= 32'h00000000;
      wstrb_q   <= 4'h0;
      o_bvalid  <= 1'b0;
      o_bresp   <= `SRC_RESP_OKAY;
      o_rvalid  <= 1'b0;
      o_rdata   <= 32'h00000000;
      o_rresp   <= `SRC_RESP_OKAY;
    end else begin
      if (i_awvalid && o_awready) begin
        aw_hold_q <= 1'b1;
        awaddr_q  <= {i_awaddr[7:2], 2'b00};
      end
      if (i_wvalid && o_wready) begin
        w_hold_q <= 1'b1;
        wdata_q  <= i_wdata;
        wstrb_q  <= i_wstrb;
      end
      if (wr_fire) begin
        aw_hold_q <= 1'b0;
        w_hold_q  <= 1'b0;
        o_bvalid  <= 1'b1;
        o_bresp   <= mapped(awaddr_q) ? `SRC_RESP_OKAY : `SRC_RESP_SLVERR;
      end else if (o_bvalid && i_bready) begin
        o_bvalid <= 1'b0;
      end
      if (rd_fire) begin
        o_rvalid <= 1'b1;
        o_rdata  <= reg_view({i_araddr[7:2], 2'b00});
        o_rresp  <= mapped({i_araddr[7:2], 2'b00}) ? `SRC_RESP_OKAY :
                    `SRC_RESP_SLVERR;
      end else if (o_rvalid && i_rready) begin
        o_rvalid <= 1'b0;
      end
    end
  end

  // ======================================================================
  // Command engine and register state.
  // Reset enters the auto-load sequence with busy shown to the host.
  always @(posedge i_clk) begin
    start_q <= 1'b0;
    if (i_srst) begin
      state_q    <= S_LOAD;
      busy_q     <= 1'b1;
      load_q     <= 1'b1;
      idx_q      <= 3'h0;
      opc_q      <= `SRC_OP_READ;
      loc_q      <= 7'h00;
      timeout_q  <= 1'b0;
      loaded_q   <= 1'b0;
      data_q     <= 8'h00;
      sta_q      <= 48'h000000000000;
      en_q       <= `SRC_PCFG_RST;
      poll_q     <= 1'b0;
      rd_op_q    <= 1'b0;
      to_cnt_q   <= 22'h000000;
      gap_q      <= 6'h00;
      sh_read_q  <= 1'b0;
      sh_nbits_q <= 5'h00;
      sh_word_q  <= 18'h00000;
      o_rom_select <= 1'b0;
    end else begin
      // Software writes; a timeout set below overrides a clear here.
      if (wr_fire) begin
        if (awaddr_q == `SRC_CMD_OFS) begin
          if (wr_merged[`SRC_CMD_TO]) begin
            timeout_q <= 1'b0;
          end
          if (!busy_q) begin
            opc_q <= wr_merged[`SRC_CMD_OPC_HI:`SRC_CMD_OPC_LO];
            loc_q <= wr_merged[`SRC_CMD_LOC_HI:0];
          end
        end else if (awaddr_q == `SRC_DATA_OFS) begin
          if (!busy_q) begin
            data_q <= wr_merged[7:0];
          end
        end else if (awaddr_q == `SRC_STAL_OFS) begin
          sta_q[31:0] <= wr_merged;
        end else if (awaddr_q == `SRC_STAH_OFS) begin
          sta_q[47:32] <= wr_merged[15:0];
        end else if (awaddr_q == `SRC_PCFG_OFS) begin
          en_q <= wr_merged[0];
        end
      end
      // Timeout counter spans issue, frame, gap and ready poll.
      if (state_q == S_SHIFT || state_q == S_GAP || state_q == S_POLL) begin
        to_cnt_q <= to_hit ? to_cnt_q : to_cnt_q + 22'h000001;
      end
      case (state_q)
        S_IDLE: begin
          if (wr_fire && awaddr_q == `SRC_CMD_OFS &&
              wr_merged[`SRC_CMD_BUSY]) begin
            busy_q   <= 1'b1;
            to_cnt_q <= 22'h000000;
            start_q  <= 1'b1;
            state_q  <= S_SHIFT;
            poll_q   <= 1'b0;
            rd_op_q  <= 1'b0;
            sh_read_q  <= 1'b0;
            sh_nbits_q <= `SRC_BITS_SHORT;
            o_rom_select <= 1'b1;
            case (wr_merged[`SRC_CMD_OPC_HI:`SRC_CMD_OPC_LO])
              `SRC_OP_READ: begin
                rd_op_q    <= 1'b1;
                sh_read_q  <= 1'b1;
                sh_nbits_q <= `SRC_BITS_LONG;
                sh_word_q  <= rom_word(`SRC_ROP_READ,
                                       wr_merged[`SRC_CMD_LOC_HI:0], 8'h00);
              end
              `SRC_OP_LOCK: begin
                sh_word_q <= rom_word(`SRC_ROP_SPECIAL, `SRC_RA_LOCK,
                                      8'h00);
              end
              `SRC_OP_UNLOCK: begin
                sh_word_q <= rom_word(`SRC_ROP_SPECIAL, `SRC_RA_UNLOCK,
                                      8'h00);
              end
              `SRC_OP_WRITE: begin
                poll_q     <= 1'b1;
                sh_nbits_q <= `SRC_BITS_LONG;
                sh_word_q  <= rom_word(`SRC_ROP_WRITE,
                                       wr_merged[`SRC_CMD_LOC_HI:0], data_q);
              end
              `SRC_OP_FILL: begin
                poll_q     <= 1'b1;
                sh_nbits_q <= `SRC_BITS_LONG;
                sh_word_q  <= rom_word(`SRC_ROP_SPECIAL, `SRC_RA_FILL,
                                       data_q);
              end
              `SRC_OP_ERASE: begin
                poll_q    <= 1'b1;
                sh_word_q <= rom_word(`SRC_ROP_ERASE,
                                      wr_merged[`SRC_CMD_LOC_HI:0], 8'h00);
              end
              `SRC_OP_ERASEALL: begin
                poll_q    <= 1'b1;
                sh_word_q <= rom_word(`SRC_ROP_SPECIAL, `SRC_RA_ERASEALL,
                                      8'h00);
              end
              default: begin
                // Reload: restart the auto-load walk from location zero.
                start_q      <= 1'b0;
                o_rom_select <= 1'b0;
                load_q   <= 1'b1;
                idx_q    <= 3'h0;
                loaded_q <= 1'b0;
                state_q  <= S_LOAD;
              end
            endcase
          end
        end
        S_LOAD: begin
          // Read of the next location in the station address walk.
          to_cnt_q   <= 22'h000000;
          start_q    <= 1'b1;
          sh_read_q  <= 1'b1;
          sh_nbits_q <= `SRC_BITS_LONG;
          sh_word_q  <= rom_word(`SRC_ROP_READ, {4'h0, idx_q}, 8'h00);
          o_rom_select <= 1'b1;
          state_q    <= S_SHIFT;
        end
        S_SHIFT: begin
          if (sh_done) begin
            o_rom_select <= 1'b0;
            gap_q <= 6'h00;
            if (load_q) begin
              if (idx_q == 3'h0 && sh_rx != `SRC_SIGNATURE) begin
                load_q  <= 1'b0;
                busy_q  <= 1'b0;
                state_q <= S_IDLE;
              end else begin
                if (idx_q != 3'h0) begin
                  sta_q[sta_slot*8 +: 8] <= sh_rx;
                end
                if (idx_q == `SRC_STA_LAST) begin
                  loaded_q <= 1'b1;
                  load_q   <= 1'b0;
                  busy_q   <= 1'b0;
                  state_q  <= S_IDLE;
                end else begin
                  idx_q   <= idx_q + 3'h1;
                  state_q <= S_LOAD;
                end
              end
            end else if (poll_q) begin
              state_q <= S_GAP;
            end else begin
              if (rd_op_q) begin
                data_q <= sh_rx;
              end
              busy_q  <= 1'b0;
              state_q <= S_IDLE;
            end
          end
        end
        S_GAP: begin
          // Select stays low for a half period so the ROM shows status.
          gap_q <= gap_q + 6'h01;
          if (gap_q == GAP_M1) begin
            o_rom_select <= 1'b1;
            state_q <= S_POLL;
          end
        end
        S_POLL: begin
          // ROM drives the data pin high once programming is over.
          if (din_sync_q || to_hit) begin
            if (!din_sync_q) begin
              timeout_q <= 1'b1;
            end
            o_rom_select <= 1'b0;
            busy_q  <= 1'b0;
            state_q <= S_IDLE;
          end
        end
        default: begin
          busy_q  <= 1'b0;
          state_q <= S_IDLE;
        end
      endcase
    end
  end

  // ======================================================================
  // Serial bit engine.
  src_shifter u_shifter (
    .i_clk      (i_clk),
    .i_srst     (i_srst),
    .i_start    (start_q),
    .i_read     (sh_read_q),
    .i_nbits    (sh_nbits_q),
    .i_word     (sh_word_q),
    .o_done     (sh_done),
    .o_rx_byte  (sh_rx),
    .o_sclk     (sh_sclk),
    .o_dout     (sh_dout),
    .o_drive    (sh_drive),
    .i_din_sync (din_sync_q)
  );

endmodule // src_engine

// ---- dv/src_engine_chk.sv ----
// Purpose: Port checker for the serial ROM engine.
// Assumes: Bound to src_engine.
// Notes:   Counters measure phase and frame lengths.
`timescale 1ns/100ps
`include "src_map.vh"
// ==========
// Checker
module src_engine_chk (
  // Clock, reset and bus.
  input wire        i_clk, i_srst, i_arvalid, o_arready,
  input wire        o_bvalid, i_bready, o_rvalid, i_rready,
  input wire [1:0]  o_bresp,
  input wire [31:0] o_rdata,
  // ROM pins.
  input wire        o_rom_select, o_rom_clock_pin_out,
  input wire        o_rom_clock_pin_oe, o_rom_data_pin_out,
  input wire        o_rom_data_pin_oe, o_pins_released
);
  reg [6:0] hi_q;
  reg [4:0] ncl_q;
  reg       ck_q;
  // High-phase length and clock count; a dropped select restarts it.
  always @(posedge i_clk) begin
    ck_q  <= o_rom_clock_pin_out;
    hi_q  <= o_rom_clock_pin_out ? hi_q + 7'h01 : 7'h00;
    ncl_q <= !o_rom_select ? 5'h00 :
             ncl_q + {4'h0, o_rom_clock_pin_out & !ck_q};
  end
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_srst);
  a_pins_free: assert property (o_pins_released |->
    !o_rom_clock_pin_oe && !o_rom_data_pin_oe) else $error("pins held");
  a_clk_count: assert property ($fell(o_rom_select) |->
    ncl_q == 5'h00 || ncl_q == 5'h0A || ncl_q == 5'h12)
    else $error("bad clock count");
  a_clk_idle: assert property (!o_rom_select [*2] |->
    !o_rom_clock_pin_out) else $error("clock outside frame");
  a_clk_high: assert property ($fell(o_rom_clock_pin_out) |->
    hi_q == `SRC_SCLK_HALF) else $error("bad high phase");
  a_data_steady: assert property (o_rom_clock_pin_out &&
    $past(o_rom_clock_pin_out) |-> $stable(o_rom_data_pin_out))
    else $error("data moved in high phase");
  a_start_bit: assert property ($rose(o_rom_data_pin_oe) |->
    o_rom_data_pin_out) else $error("no start bit");
  a_b_hold: assert property (o_bvalid && !i_bready |=>
    o_bvalid && $stable(o_bresp)) else $error("write answer lost");
  a_r_hold: assert property (o_rvalid && !i_rready |=>
    o_rvalid && $stable(o_rdata)) else $error("read answer lost");
  a_ar_answer: assert property (i_arvalid && o_arready |=> o_rvalid)
    else $error("read not answered");
  c_long: cover property ($fell(o_rom_select) && ncl_q == 5'h12);
  c_free: cover property (o_pins_released);
  c_err: cover property (o_bvalid && o_bresp == 2'h2);
endmodule // src_engine_chk

bind src_engine src_engine_chk i_chk (.*);

// ---- dv/src_rom_model.sv ----
// Purpose: Behavioural 128-byte serial ROM.
// Assumes: Pins resolved by the bench.
// Notes:   Shows ready at once after erase or write kinds.
`timescale 1ns/100ps
// ==========
// ROM model
module src_rom_model (
  // Pins.
  input  wire i_sel,
  input  wire i_sck,
  input  wire i_din,
  output reg  o_dout,
  output reg  o_doe
);
  reg [7:0]  mem [0:127];
  reg [17:0] sh;
  reg [4:0]  n;
  reg [6:0]  a;
  reg        unl, wk, rd, s0;
  integer    k;
  // Signature, six station bytes, rest erased; starts locked.
  initial begin
    for (k = 0; k < 128; k = k + 1)
      mem[k] = (k < 7) ? 8'h10 + k[7:0] : 8'hFF;
    mem[0] = 8'hA5;
    {s0, unl, wk, rd, o_doe, o_dout, n, sh} = 0;
  end
  // One owner of all state; a rising select opens a frame or ready poll.
  always @(posedge i_sck or i_sel) begin
    if (i_sel && !s0) begin
      n = 5'h00;
      rd = 1'b0;
      o_doe = wk;
      o_dout = 1'b1;
    end else if (!i_sel && s0) begin
      // Commands act when select drops after a whole frame.
      o_doe = 1'b0;
      wk = 1'b0;
      if (n == 5'h0A) begin
        if (sh[8:7] == 2'h0 && sh[6:5] != 2'h2)
          unl = sh[6];
        for (k = 0; k < 128; k = k + 1)
          if (unl && (sh[8:7] == 2'h3 ? k == sh[6:0] : sh[8:5] == 4'h2))
            mem[k] = 8'hFF;
        wk = sh[8:7] == 2'h3 || sh[8:5] == 4'h2;
      end
      if (n == 5'h12) begin
        for (k = 0; k < 128; k = k + 1)
          if (unl && (sh[16:15] == 2'h1 ? k == sh[14:8] : sh[16:13] == 4'h1))
            mem[k] = sh[7:0];
        wk = sh[16:15] == 2'h1 || sh[16:13] == 4'h1;
      end
    end else if (i_sel) begin
      // Bits enter on rising clock; read data follows the tenth.
      if (n == 5'h0A) begin
        a = sh[6:0];
        rd = sh[8:7] == 2'h2;
      end
      if (n >= 5'h0A && rd) begin
        o_doe = 1'b1;
        o_dout = mem[a][17 - n];
      end
      sh = {sh[16:0], i_din};
      n = n + 5'h01;
    end
    s0 = i_sel;
  end
endmodule // src_rom_model

// ---- dv/tb_top.sv ----
// Purpose: Bench for the serial ROM command engine.
// Assumes: ROM model on the pins, short timeout.
// Notes:   Every wait is bounded.
`timescale 1ns/100ps
`include "src_map.vh"
// ==========
// Bench top
module tb_top;
  reg         i_clk = 1'b0, i_srst = 1'b1;
  reg         awv = 1'b0, wv = 1'b0, bry = 1'b0, arv = 1'b0, rry = 1'b0;
  reg  [7:0]  adr = 8'h00;
  reg  [31:0] wd = 32'h0, q;
  reg  [1:0]  rs;
  wire        awr, wrd, bv, arr, rv, sel, cko, ckoe, dto, dtoe, mdo, mdoe, rel;
  wire [47:0] sta;
  wire [1:0]  br, rr;
  wire [31:0] rdat;
  // Lines pulled down when nobody drives them.
  wire        ckw = ckoe & cko;
  wire        dw = dtoe ? dto : (mdoe & mdo);
  integer     n_mismatch = 0, samples_checked = 0;
  src_engine #(.TIMEOUT_CYCLES(22'd3000)) i_src_engine (.i_clk(i_clk),
    .i_srst(i_srst), .i_awvalid(awv), .o_awready(awr), .i_awaddr(adr),
    .i_wvalid(wv), .o_wready(wrd), .i_wdata(wd), .i_wstrb(4'hF),
    .o_bvalid(bv), .i_bready(bry), .o_bresp(br), .i_arvalid(arv),
    .o_arready(arr), .i_araddr(adr), .o_rvalid(rv), .i_rready(rry),
    .o_rdata(rdat), .o_rresp(rr), .o_rom_select(sel),
    .o_rom_clock_pin_out(cko), .o_rom_clock_pin_oe(ckoe),
    .o_rom_data_pin_out(dto), .o_rom_data_pin_oe(dtoe),
    .i_rom_data_pin_in(dw), .o_station_addr(sta), .o_pins_released(rel));
  src_rom_model i_src_rom_model (.i_sel(sel), .i_sck(ckw), .i_din(dw),
    .o_dout(mdo), .o_doe(mdoe));
  // Clock of 10 ns.
  always #5 i_clk = !i_clk;
  task final_report;
    begin
      $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
      if (n_mismatch == 0 && samples_checked > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
    end
  endtask
  task chk(input string nm, input [31:0] e, input [31:0] g);
    begin
      samples_checked = samples_checked + 1;
      if (g !== e) begin
        n_mismatch = n_mismatch + 1;
        $display("[ERR] %s exp %h got %h", nm, e, g);
      end
    end
  endtask
  // One bus access; each channel drops once its handshake is seen.
  task bus(input w, input [7:0] a, input [31:0] d, output [31:0] o,
           output [1:0] r);
    integer n;
    reg ta, tw, tar, tb, tr;
    begin
      @(posedge i_clk);
      adr <= a; wd <= d; awv <= w; wv <= w; bry <= w; arv <= !w; rry <= !w;
      n = 0;
      #1;
      while ((awv | wv | bry | arv | rry) && n < 99) begin
        ta = awv & awr; tw = wv & wrd; tar = arv & arr;
        tb = bv & bry; tr = rv & rry;
        if (tb) r = br;
        if (tr) {o, r} = {rdat, rr};
        @(posedge i_clk);
        if (ta) awv <= 1'b0;
        if (tw) wv <= 1'b0;
        if (tar) arv <= 1'b0;
        if (tb) bry <= 1'b0;
        if (tr) rry <= 1'b0;
        n = n + 1;
        #1;
      end
      if (n == 99) begin n_mismatch = n_mismatch + 1; final_report; end
    end
  endtask
  task idle;
    integer n;
    begin
      q = 32'h80000000;
      for (n = 0; n < 9000 && q[31] !== 1'b0; n = n + 1)
        bus(0, `SRC_CMD_OFS, 0, q, rs);
      if (n == 9000) begin n_mismatch = n_mismatch + 1; final_report; end
    end
  endtask
  // Issue a command and wait until it completes.
  task op(input [2:0] c, input [6:0] l);
    begin
      bus(1, `SRC_CMD_OFS, {1'b1, c, 21'h0, l}, q, rs);
      bus(0, `SRC_CMD_OFS, 0, q, rs);
      chk("busy", 1, q[31]);
      idle;
    end
  endtask
  task rb(input [6:0] l, input [7:0] e);
    begin
      op(`SRC_OP_READ, l);
      bus(0, `SRC_DATA_OFS, 0, q, rs);
      chk("rom byte", e, q);
    end
  endtask
  // ==========
  // Scenarios
  task t_autoload;
    begin
      idle;
      chk("loaded", 1, q[8]);
      bus(0, `SRC_STAL_OFS, 0, q, rs);
      chk("sta low", 32'h14131211, q);
      bus(0, `SRC_STAH_OFS, 0, q, rs);
      chk("sta high", 32'h1615, q);
      chk("sta port", 32'h14131211, sta[31:0]);
      bus(0, `SRC_PCFG_OFS, 0, q, rs);
      chk("pin cfg", 1, q);
      $display("t_autoload done");
    end
  endtask
  task t_rw;
    begin
      bus(1, `SRC_DATA_OFS, 32'h3C, q, rs);
      op(`SRC_OP_WRITE, 7'h09);
      rb(7'h09, 8'hFF);
      op(`SRC_OP_UNLOCK, 7'h00);
      bus(1, `SRC_DATA_OFS, 32'h3C, q, rs);
      op(`SRC_OP_WRITE, 7'h09);
      chk("timeout", 0, q[9]);
      rb(7'h09, 8'h3C);
      op(`SRC_OP_ERASE, 7'h09);
      rb(7'h09, 8'hFF);
      $display("t_rw done");
    end
  endtask
  task t_bulk;
    begin
      bus(1, `SRC_DATA_OFS, 32'h5A, q, rs);
      op(`SRC_OP_FILL, 7'h00);
      rb(7'h7F, 8'h5A);
      op(`SRC_OP_ERASEALL, 7'h00);
      rb(7'h00, 8'hFF);
      op(`SRC_OP_RELOAD, 7'h00);
      chk("loaded", 0, q[8]);
      op(`SRC_OP_LOCK, 7'h00);
      bus(1, `SRC_DATA_OFS, 32'h3C, q, rs);
      op(`SRC_OP_WRITE, 7'h03);
      rb(7'h03, 8'hFF);
      $display("t_bulk done");
    end
  endtask
  task t_timeout;
    begin
      bus(1, `SRC_PCFG_OFS, 0, q, rs);
      chk("released", 1, rel);
      op(`SRC_OP_ERASE, 7'h01);
      chk("timeout", 1, q[9]);
      bus(1, `SRC_CMD_OFS, 32'h200, q, rs);
      bus(0, `SRC_CMD_OFS, 0, q, rs);
      chk("timeout clear", 0, q[9]);
      bus(0, 8'h40, 0, q, rs);
      chk("bad addr", `SRC_RESP_SLVERR, rs);
      bus(1, `SRC_PCFG_OFS, 1, q, rs);
      $display("t_timeout done");
    end
  endtask
  // Reset for three cycles, then the scenarios in turn.
  initial begin
    repeat (3) @(posedge i_clk);
    i_srst <= 1'b0;
    t_autoload;
    t_rw;
    t_bulk;
    t_timeout;
    final_report;
  end
endmodule // tb_top
